// [rtl/pcc_defs.svh]
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// APB register byte offsets
`define PCC_OFS_CTRL        12'h000
`define PCC_OFS_STATUS      12'h004
`define PCC_OFS_FREQ        12'h008
`define PCC_OFS_FCKI        12'h00c

// Control register field positions
`define PCC_BIT_POWER_ON    15
`define PCC_BIT_SOURCE_SEL  14
`define PCC_BIT_CHARGE_PUMP 13
`define PCC_BIT_SUPPLY_SEL  12
`define PCC_LSB_LOOP_FILTER 8
`define PCC_LSB_N_CODE      5
`define PCC_LSB_M_CODE      0

// Status register field positions
`define PCC_ST_READY        0
`define PCC_ST_SOURCE       1
`define PCC_ST_M_RANGE      2
`define PCC_ST_BUSY         3
`define PCC_ST_LSB_N        8
`define PCC_ST_LSB_M        16

// Reset values
`define PCC_CTRL_RESET      16'h0000
`define PCC_FCKI_KHZ_RESET  24'h002710
`define PCC_M_RESET         6'h02
`define PCC_N_RESET         4'h2

// Code decoding
`define PCC_CODE_OFFSET     8'h02
`define PCC_N_CODE_ONE      3'h7
`define PCC_N_ONE           4'h1
`define PCC_M_MAX           6'h14

// Frequency divider
`define PCC_DIV_STEPS       5'h1e

// Timing
`define PCC_CLK_PERIOD_NS   8
`define PCC_SETTLE_TIME_NS  100000

`endif

// [rtl/pcc_pkg.sv]
`default_nettype none
package pcc_pkg;

    // Control word, laid out exactly as the 16-bit register
    typedef struct packed {
        logic       power_on;
        logic       source_select;
        logic       charge_pump;
        logic       supply_sel;
        logic [3:0] loop_filter;
        logic [2:0] n_code;
        logic [4:0] m_code;
    } pcc_ctrl_t;

    // APB request as seen by the slave
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pcc_apb_req_t;

    typedef enum logic {
        PCC_DIV_IDLE,
        PCC_DIV_RUN
    } pcc_div_state_t;

endpackage
`default_nettype wire

// [rtl/pcc_settle_timer.sv]
`default_nettype none
module pcc_settle_timer
#(
    parameter int unsigned SETTLE_CYCLES = 12500
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic power_on,
    output var  logic ready
);

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        ready_next;
    wire  logic  at_end;

    // Count reaches its end one cycle before ready rises
    assign at_end     = (count_reg >= SETTLE_CYCLES - 1);
    assign count_next = !power_on ? 32'h0 : (at_end ? count_reg : count_reg + 32'h1);
    assign ready_next = power_on && at_end;

    // Powering down drops ready at once and restarts the wait
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 32'h0;
            ready     <= 1'b0;
        end
        else if (ce)
        begin
            count_reg <= count_next;
            ready     <= ready_next;
        end
    end

endmodule
`default_nettype wire

// [rtl/pcc_top.sv]
// Contract
// - Source bit picks input clock or multiplier
// - N equals code plus two; 111 means one
// - M equals code plus two, two to twenty; M above twenty is flagged, not limited
// - Internal frequency is input times M over 2N
// - Tuning fields drive analog multiplier unchanged
//
// The address map and the APB register port were chosen for this implementation.
`default_nettype none
`include "pcc_defs.svh"
module pcc_top
    import pcc_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES =
        (`PCC_SETTLE_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS
)
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             multiplier_power_on,
    output logic             clock_source_select,
    output logic             charge_pump_current,
    output logic             supply_voltage_select,
    output logic [3:0]       loop_filter_setting,
    output logic [5:0]       mult_m,
    output logic [3:0]       div_n,
    output logic             multiplier_ready,
    output logic [31:0]      internal_freq_khz
);

    // Decoded divisor N; the all-ones code is the special case of one
    function automatic logic [3:0] pcc_decode_n(input logic [2:0] code);
        logic [3:0] value;
        value = {1'b0, code} + 4'(`PCC_CODE_OFFSET);
        if (code == `PCC_N_CODE_ONE)
            value = `PCC_N_ONE;
        return value;
    endfunction

    // Decoded multiplier M
    function automatic logic [5:0] pcc_decode_m(input logic [4:0] code);
        logic [5:0] value;
        value = {1'b0, code} + 6'(`PCC_CODE_OFFSET);
        return value;
    endfunction

    // Reset release through two flops; the first feeds only the second
    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // Bus request gathered into one carrier
    pcc_apb_req_t req;
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // Address decode; only whole aligned words are mapped
    wire logic hit_ctrl;
    wire logic hit_status;
    wire logic hit_freq;
    wire logic hit_fcki;
    wire logic hit_any;
    wire logic setup_phase;
    wire logic access_phase;
    wire logic wr_ctrl;
    wire logic wr_fcki;
    wire logic wr_ro;

    assign hit_ctrl     = (req.addr == `PCC_OFS_CTRL);
    assign hit_status   = (req.addr == `PCC_OFS_STATUS);
    assign hit_freq     = (req.addr == `PCC_OFS_FREQ);
    assign hit_fcki     = (req.addr == `PCC_OFS_FCKI);
    assign hit_any      = hit_ctrl | hit_status | hit_freq | hit_fcki;
    assign setup_phase  = req.sel & ~req.enable;
    assign access_phase = req.sel & req.enable & ce;
    assign wr_ctrl      = access_phase & req.write & hit_ctrl;
    assign wr_fcki      = access_phase & req.write & hit_fcki;
    assign wr_ro        = req.write & (hit_status | hit_freq);

    // Zero wait states; a frozen block holds the access phase off
    assign pready = ce;

    // Control word and input clock rate
    pcc_ctrl_t   ctrl_reg;
    pcc_ctrl_t   ctrl_next;
    logic [23:0] fcki_khz_reg;
    logic [23:0] fcki_khz_next;

    assign ctrl_next     = wr_ctrl ? pcc_ctrl_t'(req.wdata[15:0]) : ctrl_reg;
    assign fcki_khz_next = wr_fcki ? req.wdata[23:0] : fcki_khz_reg;

    // Writes land only at the access edge
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            ctrl_reg     <= pcc_ctrl_t'(`PCC_CTRL_RESET);
            fcki_khz_reg <= `PCC_FCKI_KHZ_RESET;
        end
        else if (ce)
        begin
            ctrl_reg     <= ctrl_next;
            fcki_khz_reg <= fcki_khz_next;
        end
    end

    // Control bits straight to the analog loop and clock switch
    assign multiplier_power_on   = ctrl_reg.power_on;
    assign clock_source_select   = ctrl_reg.source_select;
    assign charge_pump_current   = ctrl_reg.charge_pump;
    assign supply_voltage_select = ctrl_reg.supply_sel;
    assign loop_filter_setting   = ctrl_reg.loop_filter;

    // Decoded factors kept in flops so they change with the control word
    logic [5:0] mult_m_next;
    logic [3:0] div_n_next;

    assign mult_m_next = pcc_decode_m(ctrl_next.m_code);
    assign div_n_next  = pcc_decode_n(ctrl_next.n_code);

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            mult_m <= `PCC_M_RESET;
            div_n  <= `PCC_N_RESET;
        end
        else if (ce)
        begin
            mult_m <= mult_m_next;
            div_n  <= div_n_next;
        end
    end

    // Values of M beyond twenty are flagged but still passed on as written
    wire logic m_out_of_range;
    assign m_out_of_range = (mult_m > `PCC_M_MAX);

    // Settle wait after power-up; software checks this before selecting
    pcc_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk      (clk),
        .rst_n    (rst_n_sync),
        .ce       (ce),
        .power_on (ctrl_reg.power_on),
        .ready    (multiplier_ready)
    );

    // Serial divider for fcki*M/(2N); area traded for 30 cycles of latency
    pcc_div_state_t div_state_reg;
    pcc_div_state_t div_state_next;
    logic [29:0]    quot_reg;
    logic [29:0]    quot_next;
    logic [5:0]     rem_reg;
    logic [5:0]     rem_next;
    logic [4:0]     den_reg;
    logic [4:0]     den_next;
    logic [4:0]     step_reg;
    logic [4:0]     step_next;
    logic [31:0]    freq_next;

    wire logic        div_start;
    wire logic [29:0] numerator;
    wire logic [4:0]  denominator;
    wire logic [5:0]  rem_shift;
    wire logic [29:0] quot_shift;
    wire logic        fits;
    wire logic        div_last;

    // Any change of rate or factors restarts the division
    assign div_start   = wr_ctrl | wr_fcki;
    assign numerator   = {6'h00, fcki_khz_next} * {24'h000000, mult_m_next};
    assign denominator = {div_n_next, 1'b0};
    assign rem_shift   = {rem_reg[4:0], quot_reg[29]};
    assign quot_shift  = {quot_reg[28:0], 1'b0};
    assign fits        = (rem_shift >= {1'b0, den_reg});
    assign div_last    = (div_state_reg == PCC_DIV_RUN) && (step_reg == 5'h01);

    // Step, start and completion logic of the divider
    always_comb
    begin
        div_state_next = div_state_reg;
        quot_next      = quot_reg;
        rem_next       = rem_reg;
        den_next       = den_reg;
        step_next      = step_reg;
        if (div_start)
        begin
            div_state_next = PCC_DIV_RUN;
            quot_next      = numerator;
            rem_next       = 6'h00;
            den_next       = denominator;
            step_next      = `PCC_DIV_STEPS;
        end
        else
        begin
            unique case (div_state_reg)
                PCC_DIV_IDLE:
                begin
                    step_next = step_reg;
                end
                PCC_DIV_RUN:
                begin
                    quot_next = fits ? (quot_shift | 30'h1) : quot_shift;
                    rem_next  = fits ? (rem_shift - {1'b0, den_reg}) : rem_shift;
                    step_next = step_reg - 5'h01;
                    if (step_reg == 5'h01)
                        div_state_next = PCC_DIV_IDLE;
                end
            endcase
        end
    end

    // Result shows the input rate when the input clock is the source
    wire logic [29:0] quot_final;
    assign quot_final = fits ? (quot_shift | 30'h1) : quot_shift;

    always_comb
    begin
        freq_next = internal_freq_khz;
        if (!ctrl_reg.source_select)
            freq_next = {8'h00, fcki_khz_reg};
        else if (div_last && !div_start)
            freq_next = {2'h0, quot_final};
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            div_state_reg     <= PCC_DIV_IDLE;
            quot_reg          <= 30'h0;
            rem_reg           <= 6'h00;
            den_reg           <= 5'h00;
            step_reg          <= 5'h00;
            internal_freq_khz <= {8'h00, `PCC_FCKI_KHZ_RESET};
        end
        else if (ce)
        begin
            div_state_reg     <= div_state_next;
            quot_reg          <= quot_next;
            rem_reg           <= rem_next;
            den_reg           <= den_next;
            step_reg          <= step_next;
            internal_freq_khz <= freq_next;
        end
    end

    // Status word shows the block's own state
    wire logic [31:0] status_word;
    assign status_word = {10'h000, mult_m, 4'h0, div_n, 4'h0,
                          (div_state_reg == PCC_DIV_RUN), m_out_of_range,
                          ctrl_reg.source_select, multiplier_ready};

    // Read mux; unmapped reads return zero
    wire logic [31:0] rdata_mux;
    assign rdata_mux = hit_ctrl   ? {16'h0000, 16'(ctrl_reg)} :
                       hit_status ? status_word :
                       hit_freq   ? internal_freq_khz :
                       hit_fcki   ? {8'h00, fcki_khz_reg} :
                                    32'h0000_0000;

    // Answer captured in the setup cycle so prdata and pslverr come from flops
    logic [31:0] prdata_next;
    logic        pslverr_next;

    assign prdata_next  = setup_phase ? (req.write ? 32'h0 : rdata_mux) : prdata;
    assign pslverr_next = setup_phase ? (~hit_any | wr_ro) : pslverr;

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            prdata  <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

endmodule
`default_nettype wire

// [verif/pcc_top_asserts.sv]
`default_nettype none
`include "pcc_defs.svh"
module pcc_top_asserts
    import pcc_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        multiplier_power_on,
    input wire logic        clock_source_select,
    input wire logic        charge_pump_current,
    input wire logic        supply_voltage_select,
    input wire logic [3:0]  loop_filter_setting,
    input wire logic [5:0]  mult_m,
    input wire logic [3:0]  div_n,
    input wire logic        multiplier_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Access edge of a control word write
    sequence s_ctrl_wr;
        psel && penable && pwrite && ce && paddr == `PCC_OFS_CTRL;
    endsequence

    a_power_bit: assert property (@(posedge clk) disable iff (!arst_n)
        s_ctrl_wr |=> multiplier_power_on == $past(pwdata[15]))
        else $error("power bit not loaded");
    a_source_bit: assert property (@(posedge clk) disable iff (!arst_n)
        s_ctrl_wr |=> clock_source_select == $past(pwdata[14]))
        else $error("source select not loaded");
    a_tuning_pass: assert property (@(posedge clk) disable iff (!arst_n)
        s_ctrl_wr |=> {charge_pump_current, supply_voltage_select,
                       loop_filter_setting} == $past(pwdata[13:8]))
        else $error("tuning fields differ");
    a_n_decode: assert property (@(posedge clk) disable iff (!arst_n)
        s_ctrl_wr |=> div_n == (($past(pwdata[7:5]) == 3'h7) ? 4'h1
                               : {1'b0, $past(pwdata[7:5])} + 4'h2))
        else $error("divider decode wrong");
    a_m_decode: assert property (@(posedge clk) disable iff (!arst_n)
        s_ctrl_wr |=> mult_m == {1'b0, $past(pwdata[4:0])} + 6'h02)
        else $error("multiplier decode wrong");
    // Ready must drop at once when powered down, a stale lock is a hazard
    a_ready_drop: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !multiplier_power_on |=> !multiplier_ready)
        else $error("ready held while powered down");
    a_ready_cause: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(multiplier_ready) |-> multiplier_power_on && $past(multiplier_power_on, 7))
        else $error("ready rose too early");
endmodule
bind pcc_top pcc_top_asserts u_chk (.clk, .arst_n, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .multiplier_power_on, .clock_source_select, .charge_pump_current,
    .supply_voltage_select, .loop_filter_setting, .mult_m, .div_n, .multiplier_ready);
`default_nettype wire

// [verif/test_pcc_top.sv]
`default_nettype none
`include "pcc_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_pcc_top
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, arst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, pwr, src, cpc, svs, rdy, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, freq, rd, st;
    logic [3:0]  lf, dn;
    logic [5:0]  mm, me;
    logic [23:0] fcki;
    pcc_ctrl_t   cw;
    int          fails = 0, n_checks = 0, k;

    pcc_top #(.SETTLE_CYCLES(8)) dut (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .multiplier_power_on(pwr),
        .clock_source_select(src), .charge_pump_current(cpc), .supply_voltage_select(svs),
        .loop_filter_setting(lf), .mult_m(mm), .div_n(dn), .multiplier_ready(rdy),
        .internal_freq_khz(freq));

    always #4 clk = ~clk;

    function automatic logic [3:0] exp_n(logic [2:0] c);
        return (c == 3'h7) ? 4'h1 : {1'b0, c} + 4'h2;
    endfunction

    // Integer quotient, as the divider truncates
    function automatic logic [31:0] exp_f(logic [23:0] f, pcc_ctrl_t c);
        return c.source_select ? ({8'h0, f} * ({27'h0, c.m_code} + 32'h2))
            / {27'h0, exp_n(c.n_code), 1'b0} : {8'h0, f};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            fails++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        rd = $urandom(34);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, `PCC_OFS_CTRL, 0);
        `CHK("ctrl reset", {16'h0, `PCC_CTRL_RESET}, rd)
        apb(0, `PCC_OFS_FCKI, 0);
        `CHK("fcki reset", {8'h0, `PCC_FCKI_KHZ_RESET}, rd)
        fcki = `PCC_FCKI_KHZ_RESET;
        $display("test reset done");
        // Every N code first, then M extremes, then random words
        for (k = 0; k < 40; k++)
        begin
            cw = 16'($urandom);
            cw.m_code = 5'($urandom_range(18, 0));
            if (k < 8)
                cw.n_code = 3'(k);
            if (k == 8)
                cw.m_code = 5'h12;
            if (k == 9)
                cw.m_code = 5'h00;
            if (k == 10)
                cw.m_code = 5'h1f;
            if (k % 5 == 4)
            begin
                fcki = 24'($urandom_range(50000, 1000));
                apb(1, `PCC_OFS_FCKI, {8'h0, fcki});
            end
            apb(1, `PCC_OFS_CTRL, {16'($urandom), cw});
            #1;
            `CHK("power", cw.power_on, pwr)
            `CHK("source", cw.source_select, src)
            `CHK("tuning", {cw.charge_pump, cw.supply_sel, cw.loop_filter}, {cpc, svs, lf})
            `CHK("n", exp_n(cw.n_code), dn)
            `CHK("m", {1'b0, cw.m_code} + 6'h02, mm)
            apb(0, `PCC_OFS_CTRL, 0);
            `CHK("ctrl read", {16'h0, cw}, rd)
            repeat (31) @(posedge clk);
            #1 `CHK("freq", exp_f(fcki, cw), freq)
            // Divider idle and settle wait long over by now
            me = {1'b0, cw.m_code} + 6'h02;
            st = {10'h0, me, 4'h0, exp_n(cw.n_code), 4'h0, 1'b0, me > 6'h14,
                  cw.source_select, cw.power_on};
            apb(0, `PCC_OFS_STATUS, 0);
            `CHK("status", st, rd)
            apb(0, `PCC_OFS_FREQ, 0);
            `CHK("freq read", exp_f(fcki, cw), rd)
        end
        $display("test decode done");
        apb(1, `PCC_OFS_CTRL, 0);
        apb(1, `PCC_OFS_CTRL, 32'h8000);
        repeat (5) @(posedge clk);
        #1 `CHK("ready early", 1'b0, rdy)
        repeat (5) @(posedge clk);
        #1 `CHK("ready", 1'b1, rdy)
        apb(1, `PCC_OFS_CTRL, 32'h4000);
        repeat (2) @(posedge clk);
        #1 `CHK("ready off", 1'b0, rdy)
        $display("test power done");
        apb(1, 12'h010, 32'hffff);
        `CHK("unmapped err", 1'b1, err)
        apb(0, `PCC_OFS_CTRL, 0);
        `CHK("ctrl kept", 32'h4000, rd)
        apb(1, `PCC_OFS_STATUS, 32'h0);
        `CHK("read-only err", 1'b1, err)
        $display("test refuse done");
        // Ten frozen edges push the settle wait out by ten
        apb(1, `PCC_OFS_CTRL, 32'h8000);
        @(posedge clk);
        ce <= 1'b0;
        repeat (9) @(posedge clk);
        #1 `CHK("ready frozen", 1'b0, rdy)
        @(posedge clk);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK("ready late", 1'b0, rdy)
        @(posedge clk);
        #1 `CHK("ready resumed", 1'b1, rdy)
        $display("test freeze done");
        // Second reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        #1 `CHK("reset ctrl", 8'h00, {pwr, src, cpc, svs, lf})
        `CHK("reset m", {1'b0, 5'h00} + 6'h02, mm)
        `CHK("reset n", exp_n(3'h0), dn)
        `CHK("reset freq", {8'h0, `PCC_FCKI_KHZ_RESET}, freq)
        `CHK("reset ready", 1'b0, rdy)
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, `PCC_OFS_FCKI, 0);
        `CHK("fcki after reset", {8'h0, `PCC_FCKI_KHZ_RESET}, rd)
        $display("test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
